// >>> logic/mpt_misc_regs.sv
`timescale 1ns/1ps
`include "mpt_defines.svh"
module mpt_misc_regs #(
  parameter logic [11:0] VERSION = 12'h5A3  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic       otp_start,
  output logic [4:0]      otp_addr,
  output logic            otp_rd,
  input  wire logic [7:0] otp_rdata,
  input  wire logic       full_power_state,
  input  wire logic       host_reset_out,
  input  wire logic       test_enable_pin,
  input  wire logic       chip_select_pin,
  input  wire logic       serial_clock_pin,
  input  wire logic       host_out_pin,
  input  wire logic       lin_tx_pin,
  input  wire logic       test_reset_pin,
  input  wire logic       test_clock_pin,
  input  wire logic       test_select_pin,
  input  wire logic       watchdog_off_pin,
  output logic [7:0]      pd_enable,
  output logic            core_reg_trim,
  output logic            periph_reg_trim,
  output logic [5:0]      bandgap_trim,
  output logic [4:0]      lin_bias_trim_field,
  output logic [7:0]      pin_in
);

  mpt_load_if ld ();

  logic [7:0] pd_enable_q;
  logic       core_q;
  logic       periph_q;
  logic [5:0] bandgap_q;
  logic [4:0] lin_bias_q;
  logic [7:0] reg_rdata_q;
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic [7:0] pin_in_q;
  logic [7:0] gate_ok;
  logic [7:0] rd_mux;

  mpt_otp_loader u_loader (
    .clk       (clk),
    .reset     (reset),
    .start     (otp_start),
    .otp_addr  (otp_addr),
    .otp_rd    (otp_rd),
    .otp_rdata (otp_rdata),
    .ld        (ld)
  );

  assign pd_enable           = pd_enable_q;
  assign core_reg_trim       = core_q;
  assign periph_reg_trim     = periph_q;
  assign bandgap_trim        = bandgap_q;
  assign lin_bias_trim_field = lin_bias_q;
  assign reg_rdata           = reg_rdata_q;
  assign pin_in              = pin_in_q;

  //////////////////////////////////////////////////////////////////////////////
  // pull-down enables
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_enable_q <= `MPT_RST_PULLDOWN;
    end else if (reg_wr && reg_addr == `MPT_ADDR_PULLDOWN) begin
      pd_enable_q <= reg_wdata;
    end
  end

  // core trim, stored value wins over a write
  always_ff @(posedge clk) begin
    if (reset) begin
      core_q <= `MPT_RST_CORE;
    end else if (ld.load) begin
      core_q <= ld.core;
    end else if (reg_wr && reg_addr == `MPT_ADDR_PWR_TRIM) begin
      core_q <= reg_wdata[`MPT_POS_CORE];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      periph_q <= `MPT_RST_PERIPH;
    end else if (ld.load) begin
      periph_q <= ld.periph;
    end else if (reg_wr && reg_addr == `MPT_ADDR_PWR_TRIM) begin
      periph_q <= reg_wdata[`MPT_POS_PERIPH];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bandgap_q <= `MPT_RST_BANDGAP;
    end else if (ld.load) begin
      bandgap_q <= ld.bandgap;
    end else if (reg_wr && reg_addr == `MPT_ADDR_PWR_TRIM) begin
      bandgap_q <= reg_wdata[7:`MPT_POS_BG_LSB];
    end
  end

  // LIN bias trim, upper bits dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      lin_bias_q <= `MPT_RST_LIN_BIAS;
    end else if (ld.load) begin
      lin_bias_q <= ld.lin_bias;
    end else if (reg_wr && reg_addr == `MPT_ADDR_LIN_TRIM) begin
      lin_bias_q <= reg_wdata[4:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux, unused bits zero
  always_comb begin
    unique case (reg_addr)
      `MPT_ADDR_PULLDOWN: rd_mux = pd_enable_q;
      `MPT_ADDR_VER_LOW:  rd_mux = VERSION[7:0];
      `MPT_ADDR_VER_HIGH: rd_mux = {4'h0, VERSION[11:8]};
      `MPT_ADDR_PWR_TRIM: rd_mux = {bandgap_q, periph_q, core_q};
      `MPT_ADDR_LIN_TRIM: rd_mux = {3'h0, lin_bias_q};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {test_enable_pin, watchdog_off_pin, test_select_pin, test_clock_pin,
                  test_reset_pin, lin_tx_pin, host_out_pin, serial_clock_pin,
                  chip_select_pin};
      sync2_q <= sync1_q;
    end
  end

  // gate bits follow the enable bit order
  assign gate_ok = {host_reset_out, {3{sync2_q[8]}}, {4{full_power_state}}};

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_in_q <= 8'h00;
    end else begin
      pin_in_q <= sync2_q[7:0] & gate_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_pd_reset_all: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> pd_enable_q == 8'hFF)
    else $error("pull-down enables not all set after reset");

  a_pd_write_map: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == 8'hB8 |=> pd_enable_q == $past(reg_wdata))
    else $error("pull-down enable write lost");

  a_serial_gate: assert property (@(posedge clk) disable iff (reset)
    !full_power_state |=> pin_in_q[3:0] == 4'h0)
    else $error("serial or LIN input passed outside full power");

  a_serial_pass: assert property (@(posedge clk) disable iff (reset)
    full_power_state |=> pin_in_q[3:0] == $past(sync2_q[3:0]))
    else $error("serial input blocked in full power");

  a_wdt_gate: assert property (@(posedge clk) disable iff (reset)
    !host_reset_out |=> !pin_in_q[7])
    else $error("watchdog-off input passed while host in reset");

  a_test_gate: assert property (@(posedge clk) disable iff (reset)
    !sync2_q[8] |=> pin_in_q[6:4] == 3'h0)
    else $error("test input passed while test enable low");

  a_version_high: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == 8'hBB |=> reg_rdata_q == {4'h0, VERSION[11:8]})
    else $error("version high byte wrong");

  a_lin_upper: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == 8'hC3 |=> reg_rdata_q[7:5] == 3'h0)
    else $error("LIN trim upper bits not zero");

  a_pwr_write: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == 8'hC0 && !ld.load
    |=> {bandgap_q, periph_q, core_q} == $past(reg_wdata))
    else $error("power trim write lost");

  a_load_trims: assert property (@(posedge clk) disable iff (reset)
    ld.load |=> lin_bias_q == $past(ld.lin_bias) && bandgap_q == $past(ld.bandgap))
    else $error("stored trims not applied");

  a_lin_write: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == 8'hC3 && !ld.load |=> lin_bias_q == $past(reg_wdata[4:0]))
    else $error("LIN trim write lost");

endmodule

// >>> logic/mpt_defines.svh
//
// Behaviour
// - Eight pull-down enable bits, one per input, write 1 connects and 0 disconnects, all 1 after reset.
// - Enable bits map chip select, serial clock, host out, LIN tx, test reset, test clock, test select, watchdog off from bit 0 to 7.
// - The three serial inputs and the LIN tx input pass only in the full power state.
// - The watchdog-off input passes only while the host reset output is high.
// - The three test inputs pass only while the test enable pin is high.
// - A read-only 12-bit version code, bits 7:0 in the low byte and bits 11:8 in the low nibble of the next.
// - Core regulator trim at bit 0, reset 0, selects 1.2V at 0 and 1.8V at 1.
// - Peripheral regulator trim at bit 1, reset 0, selects 2.5V at 0 and 3.3V at 1.
// - Bandgap trim in bits 7:2 of the power trim register, read-write, reset 011111.
// - A download with valid stored content overwrites regulator, bandgap and LIN bias trims.
// - LIN bias trim is a read-write 5-bit field in bits 4:0, reset 10000, higher code larger current.
// - Unused upper bits of version and LIN trim registers are read-only zero; software writes zero.
// - The download starts by itself after reset and stops without copying unless bit 0 or bit 4 of the validity word is set.
`ifndef MPT_DEFINES_SVH
`define MPT_DEFINES_SVH

// Register offsets
`define MPT_ADDR_PULLDOWN 8'hB8
`define MPT_ADDR_VER_LOW  8'hBA
`define MPT_ADDR_VER_HIGH 8'hBB
`define MPT_ADDR_PWR_TRIM 8'hC0
`define MPT_ADDR_LIN_TRIM 8'hC3

// Reset values
`define MPT_RST_PULLDOWN  8'hFF
`define MPT_RST_CORE      1'b0
`define MPT_RST_PERIPH    1'b0
`define MPT_RST_BANDGAP   6'h1F
`define MPT_RST_LIN_BIAS  5'h10

// Field positions in the power trim register
`define MPT_POS_CORE      0
`define MPT_POS_PERIPH    1
`define MPT_POS_BG_LSB    2

// Stored word addresses and bit positions
`define MPT_OTP_VALID     5'h00
`define MPT_OTP_LIN       5'h01
`define MPT_OTP_VDD       5'h02
`define MPT_OTP_BG        5'h03
`define MPT_OTP_IREF1     5'h05
`define MPT_OTP_LAST      5'h05
`define MPT_VALID_BIT_A   0
`define MPT_VALID_BIT_B   4
`define MPT_OTP_LIN4_BIT  2

`endif

// >>> logic/mpt_pkg.sv
package mpt_pkg;

  typedef enum logic [2:0] {
    MPT_IDLE = 3'b001,
    MPT_READ = 3'b010,
    MPT_CAPT = 3'b100
  } mpt_otp_state_type;

endpackage

// >>> logic/mpt_load_if.sv
`timescale 1ns/1ps
interface mpt_load_if;
  logic       load;
  logic       core;
  logic       periph;
  logic [5:0] bandgap;
  logic [4:0] lin_bias;

  modport src (output load, output core, output periph, output bandgap, output lin_bias);
  modport dst (input load, input core, input periph, input bandgap, input lin_bias);
endinterface

// >>> logic/mpt_otp_loader.sv
`timescale 1ns/1ps
`include "mpt_defines.svh"
module mpt_otp_loader (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  output logic [4:0]      otp_addr,
  output logic            otp_rd,
  input  wire logic [7:0] otp_rdata,
  mpt_load_if.src         ld
);

  mpt_pkg::mpt_otp_state_type state_q;
  logic [4:0]                 addr_q;
  logic                       kick_q;
  logic                       valid_word;
  logic                       last_word;

  assign valid_word = otp_rdata[`MPT_VALID_BIT_A] | otp_rdata[`MPT_VALID_BIT_B];
  assign last_word  = (addr_q == `MPT_OTP_LAST);
  assign otp_addr   = addr_q;
  assign otp_rd     = (state_q == mpt_pkg::MPT_READ);

  //////////////////////////////////////////////////////////////////////////////
  // automatic start
  always_ff @(posedge clk) begin
    if (reset) begin
      kick_q <= 1'b1;
    end else if (state_q == mpt_pkg::MPT_IDLE) begin
      kick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= mpt_pkg::MPT_IDLE;
      addr_q  <= `MPT_OTP_VALID;
    end else begin
      unique case (state_q)
        mpt_pkg::MPT_IDLE: begin
          if (kick_q || start) begin
            state_q <= mpt_pkg::MPT_READ;
            addr_q  <= `MPT_OTP_VALID;
          end
        end
        mpt_pkg::MPT_READ: begin
          state_q <= mpt_pkg::MPT_CAPT;
        end
        mpt_pkg::MPT_CAPT: begin
          if ((addr_q == `MPT_OTP_VALID && !valid_word) || last_word) begin
            state_q <= mpt_pkg::MPT_IDLE;
          end else begin
            state_q <= mpt_pkg::MPT_READ;
            addr_q  <= addr_q + 5'h01;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // gather stored trims
  always_ff @(posedge clk) begin
    if (reset) begin
      ld.core     <= `MPT_RST_CORE;
      ld.periph   <= `MPT_RST_PERIPH;
      ld.bandgap  <= `MPT_RST_BANDGAP;
      ld.lin_bias <= `MPT_RST_LIN_BIAS;
    end else if (state_q == mpt_pkg::MPT_CAPT) begin
      unique case (addr_q)
        `MPT_OTP_LIN:   ld.lin_bias[3:0] <= otp_rdata[3:0];
        `MPT_OTP_VDD: begin
          ld.core         <= otp_rdata[0];
          ld.periph       <= otp_rdata[1];
          ld.bandgap[1:0] <= otp_rdata[3:2];
        end
        `MPT_OTP_BG:    ld.bandgap[5:2] <= otp_rdata[3:0];
        `MPT_OTP_IREF1: ld.lin_bias[4] <= otp_rdata[`MPT_OTP_LIN4_BIT];
        default: begin
        end
      endcase
    end
  end

  // one load strobe after the last word
  always_ff @(posedge clk) begin
    if (reset) begin
      ld.load <= 1'b0;
    end else begin
      ld.load <= (state_q == mpt_pkg::MPT_CAPT) && last_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence seq_bad_valid;
    state_q == mpt_pkg::MPT_CAPT && addr_q == `MPT_OTP_VALID && !valid_word;
  endsequence

  sequence seq_walk_end;
    state_q == mpt_pkg::MPT_CAPT && last_word;
  endsequence

  a_invalid_stop: assert property (@(posedge clk) disable iff (reset)
    seq_bad_valid |=> state_q == mpt_pkg::MPT_IDLE ##1 !ld.load)
    else $error("download went on after invalid word");

  a_auto_start: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |=> otp_rd ##1 !otp_rd)
    else $error("download did not start after reset");

  a_walk_load: assert property (@(posedge clk) disable iff (reset)
    seq_walk_end |=> ld.load ##1 !ld.load)
    else $error("load strobe missing after last word");

endmodule

// >>> verification/mpt_otp_model.sv
`timescale 1ns/1ps
module mpt_otp_model (
  input  wire logic       clk,
  input  wire logic [4:0] otp_addr,
  input  wire logic       otp_rd,
  input  wire logic [7:0] words [0:5],
  output logic [7:0]      otp_rdata
);
  logic hold_q;

  initial begin
    otp_rdata = 8'h00;
    hold_q = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Word valid in the cycle after the strobe and one more, then scrambled
  always @(posedge clk) begin
    if (otp_rd) begin
      otp_rdata <= (otp_addr < 5'h06) ? words[otp_addr] : 8'h00;
      hold_q <= 1'b1;
    end else if (hold_q) begin
      hold_q <= 1'b0;
    end else begin
      otp_rdata <= ~otp_rdata;
    end
  end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clk;
  logic       reset;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       otp_start;
  logic [4:0] otp_addr;
  logic       otp_rd;
  logic [7:0] otp_rdata;
  logic [7:0] otp_words [0:5];
  logic [2:0] gates;
  logic [7:0] pins;
  logic [7:0] pd_enable;
  logic       core_reg_trim;
  logic       periph_reg_trim;
  logic [5:0] bandgap_trim;
  logic [4:0] lin_bias_trim_field;
  logic [7:0] pin_in;
  int         n_errors;
  int         checked;
  int         cycles;

  mpt_misc_regs u_mpt_misc_regs (
    .clk                 (clk),
    .reset               (reset),
    .reg_addr            (reg_addr),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_wdata           (reg_wdata),
    .reg_rdata           (reg_rdata),
    .otp_start           (otp_start),
    .otp_addr            (otp_addr),
    .otp_rd              (otp_rd),
    .otp_rdata           (otp_rdata),
    .full_power_state    (gates[0]),
    .host_reset_out      (gates[1]),
    .test_enable_pin     (gates[2]),
    .chip_select_pin     (pins[0]),
    .serial_clock_pin    (pins[1]),
    .host_out_pin        (pins[2]),
    .lin_tx_pin          (pins[3]),
    .test_reset_pin      (pins[4]),
    .test_clock_pin      (pins[5]),
    .test_select_pin     (pins[6]),
    .watchdog_off_pin    (pins[7]),
    .pd_enable           (pd_enable),
    .core_reg_trim       (core_reg_trim),
    .periph_reg_trim     (periph_reg_trim),
    .bandgap_trim        (bandgap_trim),
    .lin_bias_trim_field (lin_bias_trim_field),
    .pin_in              (pin_in)
  );

  mpt_otp_model u_mpt_otp_model (
    .clk       (clk),
    .otp_addr  (otp_addr),
    .otp_rd    (otp_rd),
    .words     (otp_words),
    .otp_rdata (otp_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask

  task automatic chk_trim(input logic [7:0] pwr, input logic [7:0] lin);
    #1;
    cmp({bandgap_trim, periph_reg_trim, core_reg_trim}, pwr);
    cmp({3'h0, lin_bias_trim_field}, lin);
    rd(8'hC0, pwr);
    rd(8'hC3, lin);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] vw [0:2];
    logic       ok;
    n_errors = 0;
    checked = 0;
    cycles = 0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    otp_start = 1'b0;
    gates = 3'h7;
    pins = 8'h00;
    otp_words = '{8'hEE, 8'h0A, 8'h0D, 8'h05, 8'hFF, 8'h04};
    vw = '{8'hEE, 8'h01, 8'h10};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 cmp(pd_enable, 8'hFF);
    repeat (20) @(posedge clk);
    chk_trim(8'h7C, 8'h10);
    rd(8'hB8, 8'hFF);
    rd(8'hBA, 8'hA3);
    rd(8'hBB, 8'h05);
    rd(8'hB9, 8'h00);
    wr(8'hBA, 8'h11);
    wr(8'hBB, 8'h0F);
    rd(8'hBA, 8'hA3);
    rd(8'hBB, 8'h05);
    wr(8'hB8, 8'h5A);
    #1 cmp(pd_enable, 8'h5A);
    rd(8'hB8, 8'h5A);
    wr(8'hC0, 8'h83);
    wr(8'hC3, 8'h1F);
    chk_trim(8'h83, 8'h1F);
    for (int k = 0; k < 3; k++) begin
      wr(8'hC0, 8'h00);
      wr(8'hC3, 8'h00);
      otp_words[0] = vw[k];
      @(posedge clk);
      otp_start <= 1'b1;
      @(posedge clk);
      otp_start <= 1'b0;
      repeat (20) @(posedge clk);
      ok = (k != 0);
      chk_trim(ok ? 8'h5D : 8'h00, ok ? 8'h1A : 8'h00);
      cmp(pd_enable, 8'h5A);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      gates <= i[2:0];
      pins <= 8'hFF;
      repeat (8) @(posedge clk);
      #1 cmp(pin_in, {gates[1], {3{gates[2]}}, {4{gates[0]}}});
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      pins <= j[0] ? 8'h5A : 8'hA5;
      repeat (8) @(posedge clk);
      #1 cmp(pin_in, pins);
    end
    end_sim();
  end
endmodule
